// ==== include/codec_fs_pkg.sv ====
/*
 * Shared constants, register map and carrier types for the codec frame-sync,
 * upstream shifter and interrupt block.
 * Assumes a 25 MHz system clock and an APB master with 32-bit data.
 */
package codec_fs_pkg;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_MASK = 8'h08;
    localparam logic [7:0] OFF_RTD = 8'h0c;
    localparam logic [7:0] OFF_TXDATA = 8'h10;
    localparam logic [7:0] OFF_SLOT = 8'h14;
    localparam logic [7:0] OFF_IEVT = 8'h18;
    localparam logic [7:0] OFF_IMASK = 8'h1c;
    localparam logic [7:0] OFF_ID = 8'h20;

    // identity value, arbitrary
    localparam logic [31:0] ID_VALUE = 32'h0000_a5c1;

    // control bits
    localparam int CTRL_GCI = 0;
    localparam int CTRL_OPEN_DRAIN = 1;
    localparam int CTRL_TX_ARM = 2;
    localparam int CTRL_CLK_FROM_PCM = 3;
    localparam int CTRL_MUX_SEL = 4;
    localparam int CTRL_SW_RESET = 5;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

    // status bits
    localparam int ST_RTD_CHANGE = 0;
    localparam int ST_TX_NEW = 1;
    localparam int ST_FAST_DCL = 2;
    localparam int ST_FRAME = 3;

    localparam int RTD_W = 8;
    localparam int BYTES_PER_CH = 4;
    localparam int GCI_CHANNELS = 8;
    localparam int CH_PER_GROUP = 4;
    localparam int BITS_PER_CH = 32;
    localparam int MEM_DEPTH = 16;

    // a 2.048 MHz data clock gives 256 bit clocks per 125 us frame
    localparam int FRAME_US = 125;
    localparam int SLOW_BITS_PER_FRAME = 256;
    localparam logic [9:0] FAST_THRESHOLD = 10'd384;

    // interrupt events
    localparam int EV_RTD = 0;
    localparam int EV_TX = 1;
    localparam int EV_FRAME = 2;
    localparam int EV_W = 3;

    typedef struct packed {
        logic gci_mode;
        logic open_drain;
        logic tx_arm;
        logic clk_from_pcm;
        logic mux_sel;
    } ctrl_t;

    typedef struct packed {
        logic [2:0] channel;
        logic [4:0] bit_idx;
    } slot_pos_t;

    // first channel of the group is twice the selected pair number
    function automatic logic [2:0] group_base(input logic sel_low, input logic sel_high);
        return {sel_high, sel_low, 1'b0};
    endfunction : group_base
endpackage : codec_fs_pkg

// ==== rtl/codec_tx_mem.sv ====
/*
 * Small transmit byte store: 16 words of 8 bits, one write port and one
 * registered read port.
 * Assumes a single clock; read data appear one cycle after the address.
 */
`timescale 1ns/100ps
`default_nettype none
module codec_tx_mem
    import codec_fs_pkg::*;
(
    input wire logic CLK_I,
    input wire logic we_i,
    input wire logic [3:0] waddr_i,
    input wire logic [7:0] wdata_i,
    input wire logic [3:0] raddr_i,
    output logic [7:0] rdata_o
);
    logic [7:0] mem [MEM_DEPTH];

    always_ff @(posedge CLK_I) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
        rdata_o <= mem[raddr_i];
    end
endmodule : codec_tx_mem
`default_nettype wire

// ==== rtl/codec_frame_sync_and_interrupt.sv ====
/*
 * Codec digital interface slice: GCI upstream shifter, frame alignment in
 * PCM and GCI mode, data clock rate detection, the active-low interrupt and
 * the master clock / detector multiplex select pin, with APB registers.
 * Assumes the bit clock and frame pulses are synchronous to CLK_I and are
 * sampled on it; the bit clock must be well below half of CLK_I.
 */
`timescale 1ns/100ps
`default_nettype none
module codec_frame_sync_and_interrupt
    import codec_fs_pkg::*;
(
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    input wire logic GCI_BIT_CLOCK_I,
    input wire logic PCM_FRAME_PULSE_I,
    input wire logic GCI_FRAME_PULSE_I,
    input wire logic GROUP_SELECT_LOW_I,
    input wire logic GROUP_SELECT_HIGH_I,
    input wire logic [RTD_W-1:0] REAL_TIME_DETECT_BITS_I,
    output logic GCI_UPSTREAM_OUT_O,
    output logic GCI_UPSTREAM_OE_O,
    output logic INT_N_O,
    output logic INT_N_OE_O,
    output logic IRQ_O,
    output logic DETECTOR_MUX_SELECT_O,
    output logic DETECTOR_MUX_SELECT_OE_O,
    output logic [6:0] PCM_SLOT_O
);
    ctrl_t ctrl_r, ctrl_nxt;
    logic [RTD_W-1:0] rtd_r, rtd_nxt, rtd_prev_r, rtd_prev_nxt, rtdmask_r, rtdmask_nxt;
    logic [1:0] status_r, status_nxt;
    logic [EV_W-1:0] ievt_r, ievt_nxt, imask_r, imask_nxt;
    logic fast_r, fast_nxt, half_r, half_nxt, clk_d_r, clk_d_nxt;
    logic [9:0] edge_cnt_r, edge_cnt_nxt;
    logic [7:0] bit_cnt_r, bit_cnt_nxt;
    logic [7:0] shift_r, shift_nxt;
    logic up_r, up_nxt, up_oe_r, up_oe_nxt;
    logic [6:0] slot_r, slot_nxt;
    logic [2:0] pcm_bit_r, pcm_bit_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
    logic int_n_r, int_n_nxt, int_oe_r, int_oe_nxt, irq_r, irq_nxt;
    logic mux_r, mux_nxt, mux_oe_r, mux_oe_nxt;
    logic mem_we;
    logic [3:0] mem_waddr, mem_raddr;
    logic [7:0] mem_rdata;

    logic bit_rise, data_tick, frame_pulse, wr, rd, sw_reset;
    logic in_group;
    slot_pos_t pos;

    codec_tx_mem u_mem (
        .CLK_I(CLK_I),
        .we_i(mem_we),
        .waddr_i(mem_waddr),
        .wdata_i(PWDATA_I[7:0]),
        .raddr_i(mem_raddr),
        .rdata_o(mem_rdata)
    );

    function automatic logic is_ch_in_group(input logic [2:0] ch, input logic sl, input logic sh);
        // the two selects pick one of four channel pairs, the group spans two adjacent pairs
        logic [1:0] pair;
        logic [1:0] base;
        pair = ch[2:1];
        base = {sh, sl};
        return (pair == base) || (pair == base + 2'd1);
    endfunction : is_ch_in_group

    // writes land at the edge where the master sees ready high
    assign wr = PSEL_I && PENABLE_I && PWRITE_I && pready_r;
    assign rd = PSEL_I && PENABLE_I && !PWRITE_I && !pready_r;
    assign sw_reset = wr && PADDR_I == OFF_CTRL && PWDATA_I[CTRL_SW_RESET];
    assign bit_rise = GCI_BIT_CLOCK_I && !clk_d_r;
    // with a 4.096 MHz clock only every second rising edge moves data
    assign data_tick = bit_rise && (!fast_r || half_r);
    assign frame_pulse = ctrl_r.gci_mode ? GCI_FRAME_PULSE_I : PCM_FRAME_PULSE_I;
    // position of the bit that starts at this tick; a frame pulse restarts at bit 0
    assign pos = (bit_rise && frame_pulse) ? slot_pos_t'(8'h00) : slot_pos_t'(bit_cnt_r + 8'd1);
    assign in_group = is_ch_in_group(pos.channel, GROUP_SELECT_LOW_I, GROUP_SELECT_HIGH_I);
    assign mem_we = wr && PADDR_I == OFF_TXDATA;
    assign mem_waddr = PWDATA_I[11:8];
    // prefetch for the next bit; bit 0 is fetched at count 255, so a frame pulse off the
    // 256-bit grid sends one stale first byte
    assign mem_raddr = {2'(pos.channel - group_base(GROUP_SELECT_LOW_I, GROUP_SELECT_HIGH_I)), pos.bit_idx[4:3]};

    always_comb begin
        ctrl_nxt = ctrl_r;
        rtdmask_nxt = rtdmask_r;
        imask_nxt = imask_r;
        status_nxt = status_r;
        ievt_nxt = ievt_r;
        prdata_nxt = prdata_r;
        pready_nxt = 1'b0;
        pslverr_nxt = 1'b0;
        rtd_nxt = REAL_TIME_DETECT_BITS_I;
        rtd_prev_nxt = rtd_r;
        if (PSEL_I && PENABLE_I && !pready_r) begin
            pready_nxt = 1'b1;
            prdata_nxt = 32'h0000_0000;
            case (PADDR_I)
                OFF_CTRL: prdata_nxt = {27'h0, ctrl_r.mux_sel, ctrl_r.clk_from_pcm, ctrl_r.tx_arm,
                                        ctrl_r.open_drain, ctrl_r.gci_mode};
                OFF_STATUS: prdata_nxt = {28'h0, frame_seen(), fast_r, status_r};
                OFF_MASK: prdata_nxt = {24'h0, rtdmask_r};
                OFF_RTD: prdata_nxt = {24'h0, rtd_r};
                OFF_TXDATA: prdata_nxt = 32'h0000_0000;
                OFF_SLOT: prdata_nxt = {18'h0, pcm_bit_r, 4'h0, slot_r};
                OFF_IEVT: prdata_nxt = {29'h0, ievt_r};
                OFF_IMASK: prdata_nxt = {29'h0, imask_r};
                OFF_ID: prdata_nxt = ID_VALUE;
                default: pslverr_nxt = 1'b1;
            endcase
            // reading the status register releases the interrupt
            // cleared where the data is captured, so no event slips between capture and clear
            if (rd && PADDR_I == OFF_STATUS) begin
                status_nxt = 2'b00;
            end
        end
        if (wr) begin
            case (PADDR_I)
                OFF_CTRL: begin
                    ctrl_nxt.gci_mode = PWDATA_I[CTRL_GCI];
                    ctrl_nxt.open_drain = PWDATA_I[CTRL_OPEN_DRAIN];
                    ctrl_nxt.tx_arm = PWDATA_I[CTRL_TX_ARM];
                    ctrl_nxt.clk_from_pcm = PWDATA_I[CTRL_CLK_FROM_PCM];
                    ctrl_nxt.mux_sel = PWDATA_I[CTRL_MUX_SEL];
                end
                OFF_MASK: rtdmask_nxt = PWDATA_I[RTD_W-1:0];
                OFF_IMASK: imask_nxt = PWDATA_I[EV_W-1:0];
                OFF_IEVT: ievt_nxt = ievt_r & ~PWDATA_I[EV_W-1:0];
                default: ;
            endcase
        end
        // events set after the read and IEVT clears so a same-cycle event wins; a software reset clears them all
        if (((rtd_r ^ rtd_prev_r) & ~rtdmask_r) != '0) begin
            status_nxt[ST_RTD_CHANGE] = 1'b1;
            ievt_nxt[EV_RTD] = 1'b1;
        end
        if (mem_we) begin
            ievt_nxt[EV_TX] = 1'b1;
            if (ctrl_r.tx_arm) begin
                status_nxt[ST_TX_NEW] = 1'b1;
            end
        end
        if (bit_rise && frame_pulse) begin
            ievt_nxt[EV_FRAME] = 1'b1;
        end
        if (sw_reset) begin
            ctrl_nxt = ctrl_t'(CTRL_RESET[4:0]);
            status_nxt = 2'b00;
            ievt_nxt = '0;
        end
    end

    function automatic logic frame_seen();
        return ievt_r[EV_FRAME];
    endfunction : frame_seen

    // bit clock rate detection and frame alignment
    always_comb begin
        clk_d_nxt = GCI_BIT_CLOCK_I;
        fast_nxt = fast_r;
        half_nxt = half_r;
        edge_cnt_nxt = edge_cnt_r;
        bit_cnt_nxt = bit_cnt_r;
        slot_nxt = slot_r;
        pcm_bit_nxt = pcm_bit_r;
        shift_nxt = shift_r;
        up_nxt = up_r;
        up_oe_nxt = up_oe_r;
        if (bit_rise) begin
            half_nxt = !half_r;
            if (edge_cnt_r != 10'h3ff) begin
                edge_cnt_nxt = edge_cnt_r + 10'd1;
            end
            if (frame_pulse) begin
                // 384 or more rising edges per frame means the 4.096 MHz clock
                fast_nxt = edge_cnt_r >= FAST_THRESHOLD;
                edge_cnt_nxt = 10'd1;
                // bit 0 spans this rise and the next one in the fast case
                half_nxt = 1'b0;
            end
        end
        if (bit_rise && frame_pulse) begin
            bit_cnt_nxt = 8'h00;
            slot_nxt = 7'h00;
            pcm_bit_nxt = 3'h0;
        end else if (data_tick) begin
            bit_cnt_nxt = bit_cnt_r + 8'd1;
            pcm_bit_nxt = pcm_bit_r + 3'd1;
            if (pcm_bit_r == 3'h7) begin
                slot_nxt = slot_r + 7'd1;
            end
        end
        if (data_tick || (bit_rise && frame_pulse)) begin
            if (ctrl_r.gci_mode && in_group) begin
                up_oe_nxt = 1'b1;
                if (pos.bit_idx[2:0] == 3'h0) begin
                    up_nxt = mem_rdata[7];
                    shift_nxt = {mem_rdata[6:0], 1'b0};
                end else begin
                    up_nxt = shift_r[7];
                    shift_nxt = {shift_r[6:0], 1'b0};
                end
            end else begin
                up_oe_nxt = 1'b0;
                up_nxt = 1'b1;
            end
        end
    end

    // interrupt and multiplexed pin drive
    always_comb begin
        irq_nxt = (ievt_r & imask_r) != '0;
        int_n_nxt = !(status_r != 2'b00);
        // open drain only pulls low; push-pull drives both levels
        int_oe_nxt = ctrl_r.open_drain ? !int_n_nxt : 1'b1;
        mux_oe_nxt = ctrl_r.gci_mode || ctrl_r.clk_from_pcm;
        mux_nxt = mux_oe_nxt && ctrl_r.mux_sel;
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            ctrl_r <= ctrl_t'(CTRL_RESET[4:0]);
            rtd_r <= '0;
            rtd_prev_r <= '0;
            rtdmask_r <= '1;
            status_r <= 2'b00;
            ievt_r <= '0;
            imask_r <= '0;
            prdata_r <= 32'h0000_0000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            rtd_r <= rtd_nxt;
            rtd_prev_r <= rtd_prev_nxt;
            rtdmask_r <= rtdmask_nxt;
            status_r <= status_nxt;
            ievt_r <= ievt_nxt;
            imask_r <= imask_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            // a clock already high at release is not a rise
            clk_d_r <= 1'b1;
            fast_r <= 1'b0;
            half_r <= 1'b0;
            edge_cnt_r <= 10'h000;
            bit_cnt_r <= 8'h00;
            slot_r <= 7'h00;
            pcm_bit_r <= 3'h0;
            shift_r <= 8'h00;
            up_r <= 1'b1;
            up_oe_r <= 1'b0;
            int_n_r <= 1'b1;
            int_oe_r <= 1'b0;
            irq_r <= 1'b0;
            mux_r <= 1'b0;
            mux_oe_r <= 1'b0;
        end else begin
            clk_d_r <= clk_d_nxt;
            fast_r <= fast_nxt;
            half_r <= half_nxt;
            edge_cnt_r <= edge_cnt_nxt;
            bit_cnt_r <= bit_cnt_nxt;
            slot_r <= slot_nxt;
            pcm_bit_r <= pcm_bit_nxt;
            shift_r <= shift_nxt;
            up_r <= up_nxt;
            up_oe_r <= up_oe_nxt;
            int_n_r <= int_n_nxt;
            int_oe_r <= int_oe_nxt;
            irq_r <= irq_nxt;
            mux_r <= mux_nxt;
            mux_oe_r <= mux_oe_nxt;
        end
    end

    assign PRDATA_O = prdata_r;
    assign PREADY_O = pready_r;
    assign PSLVERR_O = pslverr_r;
    assign GCI_UPSTREAM_OUT_O = up_r;
    assign GCI_UPSTREAM_OE_O = up_oe_r;
    assign INT_N_O = int_n_r;
    assign INT_N_OE_O = int_oe_r;
    assign IRQ_O = irq_r;
    assign DETECTOR_MUX_SELECT_O = mux_r;
    assign DETECTOR_MUX_SELECT_OE_O = mux_oe_r;
    assign PCM_SLOT_O = slot_r;
endmodule : codec_frame_sync_and_interrupt
`default_nettype wire

// ==== testbench/codec_fs_properties.sv ====
/* port checker for the codec frame block
   assumes the single CLK_I domain; bound at the foot */
`timescale 1ns/100ps
`default_nettype none
module codec_fs_properties
    import codec_fs_pkg::*;
(
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic [31:0] PRDATA_O,
    input wire logic PREADY_O,
    input wire logic PSLVERR_O,
    input wire logic GCI_BIT_CLOCK_I,
    input wire logic GCI_UPSTREAM_OUT_O,
    input wire logic GCI_UPSTREAM_OE_O,
    input wire logic INT_N_O,
    input wire logic INT_N_OE_O,
    input wire logic IRQ_O
);
    logic brk, clk_q;
    logic [3:0] age_r;
    // a status read or a software reset may release the interrupt
    assign brk = PSEL_I && (PWRITE_I ? PADDR_I == OFF_CTRL && PWDATA_I[CTRL_SW_RESET] : PADDR_I == OFF_STATUS);
    always_ff @(posedge CLK_I) begin
        clk_q <= GCI_BIT_CLOCK_I;
        if (RST_I || (GCI_BIT_CLOCK_I && !clk_q)) begin
            age_r <= 4'h0;
        end else if (age_r != 4'hf) begin
            age_r <= age_r + 4'h1;
        end
    end
    default clocking @(posedge CLK_I);
    endclocking
    default disable iff (RST_I);
    a_ready_wait: assert property (PSEL_I && PENABLE_I && !PREADY_O |=> PREADY_O)
        else $error("no ready after access");
    a_ready_pulse: assert property (PREADY_O |=> !PREADY_O)
        else $error("ready longer than one cycle");
    a_ready_cause: assert property (PREADY_O |-> $past(PSEL_I && PENABLE_I))
        else $error("ready without access");
    a_err_ready: assert property (PSLVERR_O |-> PREADY_O)
        else $error("error without ready");
    a_err_zero: assert property (PSLVERR_O && !PWRITE_I |-> PRDATA_O == 32'h0)
        else $error("refused read data not zero");
    a_int_hold: assert property (
        !INT_N_O && !brk && !$past(brk) && !$past(brk, 2) |=> !INT_N_O)
        else $error("interrupt released early");
    a_int_after_rst: assert property ($fell(RST_I) |-> INT_N_O && !IRQ_O)
        else $error("interrupt active after reset");
    a_int_drive: assert property (!INT_N_O |-> INT_N_OE_O)
        else $error("low interrupt not driven");
    a_up_idle: assert property (!GCI_UPSTREAM_OE_O |-> GCI_UPSTREAM_OUT_O)
        else $error("undriven upstream not idle");
    a_up_timing: assert property (
        $changed(GCI_UPSTREAM_OUT_O) && GCI_UPSTREAM_OE_O |-> age_r <= 4'h3)
        else $error("upstream bit moved off clock");
endmodule : codec_fs_properties
bind codec_frame_sync_and_interrupt codec_fs_properties chk (
    .CLK_I(CLK_I), .RST_I(RST_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
    .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O),
    .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .GCI_BIT_CLOCK_I(GCI_BIT_CLOCK_I),
    .GCI_UPSTREAM_OUT_O(GCI_UPSTREAM_OUT_O), .GCI_UPSTREAM_OE_O(GCI_UPSTREAM_OE_O),
    .INT_N_O(INT_N_O), .INT_N_OE_O(INT_N_OE_O), .IRQ_O(IRQ_O)
);
`default_nettype wire

// ==== testbench/gci_backplane_model.sv ====
/* far-side model: backplane controller making a 2.048 MHz style data
   clock (8 CLK_I per bit) and frame pulses, capturing the upstream line */
`timescale 1ns/100ps
`default_nettype none
module gci_backplane_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic up_i,
    input wire logic up_oe_i,
    output logic bit_clk_o,
    output logic frame_o,
    output logic [7:0] bit_idx_o,
    output logic [255:0] bits_o,
    output logic [255:0] oe_o,
    output logic [7:0] frames_o
);
    logic [2:0] ph_r;
    logic [255:0] cap_r;
    logic [255:0] cap_oe_r;
    // clock and pulse come from one counter so they stay in step
    // no separate master clock is offered; the data clock is divided down from the processor clock
    assign bit_clk_o = ph_r < 3'h4;
    assign frame_o = bit_idx_o == 8'h00;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ph_r <= 3'h0;
            bit_idx_o <= 8'hff;
            frames_o <= 8'h00;
        end else begin
            ph_r <= ph_r + 3'h1;
            if (ph_r == 3'h7) begin
                bit_idx_o <= bit_idx_o + 8'h01;
            end
            // sample late in the bit, well after the line has settled
            if (ph_r == 3'h5) begin
                cap_r[bit_idx_o] <= up_i;
                cap_oe_r[bit_idx_o] <= up_oe_i;
            end
            if (ph_r == 3'h6 && bit_idx_o == 8'hff) begin
                bits_o <= cap_r;
                oe_o <= cap_oe_r;
                frames_o <= frames_o + 8'h01;
            end
        end
    end
endmodule : gci_backplane_model
`default_nettype wire

// ==== testbench/tb_codec_frame_sync_and_interrupt.sv ====
/* self-checking bench: APB tasks, backplane model on the serial side
   assumes the package and design files are compiled first */
`timescale 1ns/100ps
`default_nettype none
module tb_codec_frame_sync_and_interrupt
    import codec_fs_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, q;
    logic pready, pslverr, e, bclk, fp, up, up_oe, int_n, int_oe, irq, mux, mux_oe;
    logic [RTD_W-1:0] rtd = 8'h00;
    logic [6:0] slot;
    logic [7:0] bidx, frames, f0;
    logic [255:0] gbits, goe;
    int fails = 0;
    int checks = 0;
    int cyc = 0;
    initial forever #20 clk = ~clk;
    codec_frame_sync_and_interrupt uut (.CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable),
        .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
        .PSLVERR_O(pslverr), .GCI_BIT_CLOCK_I(bclk), .PCM_FRAME_PULSE_I(fp), .GCI_FRAME_PULSE_I(fp),
        .GROUP_SELECT_LOW_I(1'b1), .GROUP_SELECT_HIGH_I(1'b0), .REAL_TIME_DETECT_BITS_I(rtd),
        .GCI_UPSTREAM_OUT_O(up), .GCI_UPSTREAM_OE_O(up_oe), .INT_N_O(int_n), .INT_N_OE_O(int_oe),
        .IRQ_O(irq), .DETECTOR_MUX_SELECT_O(mux), .DETECTOR_MUX_SELECT_OE_O(mux_oe), .PCM_SLOT_O(slot));
    gci_backplane_model model (.clk_i(clk), .rst_i(rst), .up_i(up), .up_oe_i(up_oe), .bit_clk_o(bclk),
        .frame_o(fp), .bit_idx_o(bidx), .bits_o(gbits), .oe_o(goe), .frames_o(frames));
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            fails++;
            report_and_stop();
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string m);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : check
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // register outputs follow a write by two edges
        repeat (2) @(posedge clk);
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string m);
        apb(1'b0, a, 32'h0);
        check(q, exp, m);
    endtask : rd
    task automatic wait_n(input int n);
        repeat (n) @(posedge clk);
    endtask : wait_n
    function automatic logic [7:0] byte_at(input int pos);
        for (int k = 0; k < 8; k++) byte_at[7 - k] = gbits[pos + k];
    endfunction : byte_at
    initial begin
        wait_n(5);
        rst <= 1'b0;
        wait_n(1);
        check(int_n, 1'b1, "int idle");
        rd(OFF_CTRL, 32'h0, "ctrl reset");
        rd(OFF_MASK, 32'hff, "mask reset");
        rd(8'h40, 32'h0, "unmapped data");
        check(e, 1'b1, "unmapped err");
        $display("test regs done");
        apb(1'b1, OFF_MASK, 32'hfe);
        rtd <= 8'h02;
        wait_n(6);
        check(int_n, 1'b1, "masked bit");
        rtd <= 8'h03;
        wait_n(6);
        check(int_n, 1'b0, "unmasked bit");
        check(int_oe, 1'b1, "push-pull drive");
        apb(1'b1, OFF_IMASK, 32'h1);
        check(irq, 1'b1, "irq raised");
        apb(1'b1, OFF_IEVT, 32'h1);
        check(irq, 1'b0, "irq cleared");
        wait_n(20);
        check(int_n, 1'b0, "int held");
        rd(OFF_STATUS, (32'h1 << ST_RTD_CHANGE) | (32'h1 << ST_FRAME), "rtd status");
        wait_n(4);
        check(int_n, 1'b1, "int released");
        apb(1'b1, OFF_CTRL, 32'h2);
        check(int_oe, 1'b0, "open drain off");
        rtd <= 8'h02;
        wait_n(6);
        check(int_oe, 1'b1, "open drain pulls");
        apb(1'b0, OFF_STATUS, 32'h0);
        $display("test detector done");
        apb(1'b1, OFF_TXDATA, 32'h0a5);
        wait_n(6);
        check(int_n, 1'b1, "tx unarmed");
        apb(1'b1, OFF_CTRL, 32'h4);
        apb(1'b1, OFF_TXDATA, 32'h63c);
        wait_n(6);
        check(int_n, 1'b0, "tx armed");
        apb(1'b1, OFF_CTRL, 32'h20);
        check(int_n, 1'b1, "sw reset release");
        $display("test tx done");
        apb(1'b1, OFF_CTRL, 32'h1);
        check(mux_oe, 1'b1, "mux pin in gci");
        f0 = frames;
        for (int i = 0; i < 6000 && 8'(frames - f0) < 8'd2; i++) @(posedge clk);
        check(byte_at(64), 8'ha5, "ch2 byte0");
        check(byte_at(112), 8'h3c, "ch3 byte2");
        check(32'(&goe[191:64]), 32'h1, "group lanes");
        check(32'(|{goe[255:192], goe[63:0]}), 32'h0, "other lanes");
        $display("test gci done");
        apb(1'b1, OFF_CTRL, 32'h0);
        check(mux_oe, 1'b0, "mux pin off");
        for (int i = 0; i < 3000 && bidx !== 8'd42; i++) @(posedge clk);
        wait_n(4);
        check(slot, 7'd5, "pcm slot");
        apb(1'b1, OFF_CTRL, 32'h18);
        check(mux_oe, 1'b1, "mux pin pcm clock");
        check(mux, 1'b1, "mux select level");
        $display("test pcm done");
        report_and_stop();
    end
endmodule : tb_codec_frame_sync_and_interrupt
`default_nettype wire
